// ---- hw/tcc_top.sv ----
// compare/capture channel with its apb register file
// assumes a selected timebase and instruction phase on pclk
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tcc_top #(
    parameter int VALUE_W = tcc_pkg::VALUE_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input tcc_pkg::tcc_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input tcc_pkg::tcc_timebase_t timebase,
    input wire logic instruction_start_phase,
    input wire logic channel_pin_in,
    output logic channel_pin_out,
    output logic channel_pin_oe_n,
    output logic rto_irq,
    output logic cap_irq,
    output logic [1:0] sibling_mode,
    output logic [15:0] capture_edge_select
);
    generate
        if (VALUE_W != 16) begin : g_bad_width
            $error("tcc_top supports a 16-bit value only");
        end
    endgenerate

    // decode: bit 2 is the hit, bits 1:0 the register index
    function automatic logic [2:0] tcc_decode(input logic [11:0] a);
        logic [2:0] d;
        d = 3'h0;
        unique case (a)
            tcc_pkg::OFF_VALUE: d = {1'b1, tcc_pkg::IDX_VALUE};
            tcc_pkg::OFF_OUTCTL: d = {1'b1, tcc_pkg::IDX_OUTCTL};
            tcc_pkg::OFF_FSEL: d = {1'b1, tcc_pkg::IDX_FSEL};
            tcc_pkg::OFF_EDGE: d = {1'b1, tcc_pkg::IDX_EDGE};
            default: d = 3'h0;
        endcase
        return d;
    endfunction

    tcc_pkg::tcc_bus_state_t bus_st_r;
    tcc_pkg::tcc_bus_state_t bus_st_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    logic [15:0] value_r;
    logic [15:0] value_nxt;
    logic lvl_r;
    logic lvl_nxt;
    logic next_lvl_r;
    logic next_lvl_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [2:0] fsel_r;
    logic [2:0] fsel_nxt;
    logic [15:0] edge_r;
    logic [15:0] edge_nxt;
    logic wrap_seen_r;
    logic wrap_seen_nxt;
    logic rto_pend_r;
    logic rto_pend_nxt;
    logic cap_pend_r;
    logic cap_pend_nxt;
    logic rto_irq_r;
    logic rto_irq_nxt;
    logic cap_irq_r;
    logic cap_irq_nxt;
    logic oe_n_r;
    logic oe_n_nxt;

    logic [2:0] dec;
    logic hit;
    logic access;
    logic wr_take;
    logic [31:0] rd_word;
    logic cap_mode;
    logic match;
    logic fire;
    logic rto_evt;
    logic wrap_evt;
    logic pin_rise;
    logic pin_fall;
    logic [1:0] edge_code;
    logic cap_edge;
    logic cap_evt;

    tcc_match #(
        .WIDTH(VALUE_W)
    ) u_match (
        .count(timebase.count),
        .value(value_r),
        .run(timebase.run),
        .tick(timebase.tick),
        .match(match),
        .fire(fire)
    );

    tcc_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin_in(channel_pin_in),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign dec = tcc_decode(apb_req.paddr);
    assign hit = dec[2];
    assign access = apb_req.psel && apb_req.penable;
    // a write lands only on the edge where pready is sampled high
    assign wr_take = (bus_st_r == tcc_pkg::TCC_BUS_ACK) && access &&
                     apb_req.pwrite && hit;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (dec[1:0])
            tcc_pkg::IDX_VALUE: rd_word = {16'h0000, value_r};
            tcc_pkg::IDX_OUTCTL: rd_word = {24'h00_0000,
                tcc_pkg::UPPER_ONES | {5'h00, flag_r, next_lvl_r, lvl_r}};
            tcc_pkg::IDX_FSEL: rd_word = {24'h00_0000,
                tcc_pkg::FSEL_FIXED | {5'h00, fsel_r}};
            tcc_pkg::IDX_EDGE: rd_word = {16'h0000, edge_r};
        endcase
    end

    // bus: one wait state, then the answer for one cycle
    always_comb begin
        bus_st_nxt = bus_st_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        unique case (bus_st_r)
            tcc_pkg::TCC_BUS_IDLE: begin
                if (access) begin
                    bus_st_nxt = tcc_pkg::TCC_BUS_ACK;
                    pready_nxt = 1'b1;
                    pslverr_nxt = !hit;
                    prdata_nxt = (hit && !apb_req.pwrite) ? rd_word
                                                          : 32'h0000_0000;
                end
            end
            tcc_pkg::TCC_BUS_ACK: begin
                bus_st_nxt = tcc_pkg::TCC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_st_r <= tcc_pkg::TCC_BUS_IDLE;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            bus_st_r <= bus_st_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign cap_mode = fsel_r[tcc_pkg::FSEL_CAP_BIT];
    assign rto_evt = fire && !cap_mode;
    assign wrap_evt = fire && cap_mode;
    assign edge_code = edge_r[tcc_pkg::EDGE_CH_LSB +: 2];
    assign cap_edge = ((edge_code == tcc_pkg::EDGE_FALL) && pin_fall) ||
                      ((edge_code == tcc_pkg::EDGE_RISE) && pin_rise) ||
                      (edge_code[tcc_pkg::EDGE_BOTH_BIT] &&
                       (pin_rise || pin_fall));
    assign cap_evt = cap_mode && timebase.run && cap_edge;

    // channel: registers, capture, output level and requests
    always_comb begin
        value_nxt = value_r;
        lvl_nxt = lvl_r;
        next_lvl_nxt = next_lvl_r;
        flag_nxt = flag_r;
        fsel_nxt = fsel_r;
        edge_nxt = edge_r;
        wrap_seen_nxt = wrap_seen_r;
        oe_n_nxt = cap_mode;
        if (wr_take) begin
            unique case (dec[1:0])
                tcc_pkg::IDX_VALUE: value_nxt = apb_req.pwdata[15:0];
                tcc_pkg::IDX_OUTCTL: begin
                    lvl_nxt = apb_req.pwdata[tcc_pkg::OUT_LVL_BIT];
                    next_lvl_nxt = apb_req.pwdata[tcc_pkg::NEXT_LVL_BIT];
                    // writing one leaves the flag alone
                    flag_nxt = flag_r &&
                               apb_req.pwdata[tcc_pkg::CYC_FLAG_BIT];
                end
                tcc_pkg::IDX_FSEL: fsel_nxt = apb_req.pwdata[2:0];
                tcc_pkg::IDX_EDGE: edge_nxt = apb_req.pwdata[15:0];
            endcase
        end
        if (rto_evt) begin
            lvl_nxt = next_lvl_r;
        end
        if (!cap_mode) begin
            wrap_seen_nxt = 1'b0;
        end else if (cap_evt) begin
            value_nxt = timebase.count;
            wrap_seen_nxt = 1'b0;
            if (wrap_seen_r || wrap_evt) begin
                flag_nxt = 1'b1;
            end
        end else if (wrap_evt) begin
            // counter came back round to the last capture
            wrap_seen_nxt = 1'b1;
        end
    end

    // requests wait for the start phase; a new event beats the clear
    always_comb begin
        rto_irq_nxt = rto_pend_r && instruction_start_phase;
        cap_irq_nxt = cap_pend_r && instruction_start_phase;
        rto_pend_nxt = (rto_pend_r && !instruction_start_phase) ||
                       rto_evt;
        cap_pend_nxt = (cap_pend_r && !instruction_start_phase) ||
                       cap_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_r <= tcc_pkg::VALUE_RST;
            lvl_r <= tcc_pkg::OUTCTL_RST[tcc_pkg::OUT_LVL_BIT];
            next_lvl_r <= tcc_pkg::OUTCTL_RST[tcc_pkg::NEXT_LVL_BIT];
            flag_r <= tcc_pkg::OUTCTL_RST[tcc_pkg::CYC_FLAG_BIT];
            fsel_r <= tcc_pkg::FSEL_RST[2:0];
            edge_r <= tcc_pkg::EDGE_RST;
            wrap_seen_r <= 1'b0;
            oe_n_r <= tcc_pkg::FSEL_RST[tcc_pkg::FSEL_CAP_BIT];
            rto_pend_r <= 1'b0;
            cap_pend_r <= 1'b0;
            rto_irq_r <= 1'b0;
            cap_irq_r <= 1'b0;
        end else if (clk_en) begin
            value_r <= value_nxt;
            lvl_r <= lvl_nxt;
            next_lvl_r <= next_lvl_nxt;
            flag_r <= flag_nxt;
            fsel_r <= fsel_nxt;
            edge_r <= edge_nxt;
            wrap_seen_r <= wrap_seen_nxt;
            oe_n_r <= oe_n_nxt;
            rto_pend_r <= rto_pend_nxt;
            cap_pend_r <= cap_pend_nxt;
            rto_irq_r <= rto_irq_nxt;
            cap_irq_r <= cap_irq_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign channel_pin_out = lvl_r;
    assign channel_pin_oe_n = oe_n_r;
    assign rto_irq = rto_irq_r;
    assign cap_irq = cap_irq_r;
    assign sibling_mode = fsel_r[tcc_pkg::FSEL_SIB_LSB +: 2];
    assign capture_edge_select = edge_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    cmp_copy_level_a: assert property (
        clk_en && rto_evt |=> lvl_r == $past(next_lvl_r))
        else $error("output level not copied from next level");

    cmp_match_only_a: assert property (
        rto_evt |-> timebase.count == value_r && timebase.tick)
        else $error("compare event without counter match");

    idle_timebase_a: assert property (
        !timebase.run |-> !rto_evt && !cap_evt)
        else $error("activity while timebase stopped");

    cap_load_count_a: assert property (
        clk_en && cap_evt |=> value_r == $past(timebase.count))
        else $error("capture did not load counter value");

    cap_request_a: assert property (
        clk_en && cap_evt |=> cap_pend_r)
        else $error("capture request not raised");

    irq_phase_a: assert property (
        $rose(rto_irq_r) || $rose(cap_irq_r) |->
        $past(instruction_start_phase))
        else $error("request outside instruction start phase");

    cap_quiet_out_a: assert property (
        clk_en && cap_mode && !wr_take |=> $stable(lvl_r))
        else $error("output level moved in capture mode");

    flag_capture_only_a: assert property (
        clk_en && !flag_r && !cap_evt |=> !flag_r)
        else $error("cycle flag set without capture");

    flag_set_wrap_a: assert property (
        clk_en && cap_evt && wrap_seen_r |=> flag_r)
        else $error("cycle flag missed after full cycle");

    ctl_upper_ones_a: assert property (
        clk_en && bus_st_r == tcc_pkg::TCC_BUS_IDLE && access &&
        !apb_req.pwrite && hit && dec[1:0] == tcc_pkg::IDX_OUTCTL
        |=> prdata_r[7:3] == 5'h1F && pready_r)
        else $error("upper control bits not read as ones");

    bus_answer_a: assert property (
        clk_en && bus_st_r == tcc_pkg::TCC_BUS_IDLE && access |=>
        pready_r ##1 (!pready_r || !$past(clk_en)))
        else $error("bus answer not one cycle after access");

    rto_event_c: cover property (clk_en && rto_evt);
    cap_event_c: cover property (clk_en && cap_evt);
    cap_wrap_c: cover property (clk_en && cap_evt && wrap_seen_r);
    irq_out_c: cover property (rto_irq_r ##1 cap_irq_r [*1]);
endmodule

// ---- inc/tcc_pkg.sv ----
// constants, field layouts and carriers of the compare/capture channel
// assumes an apb master on pclk and a timebase on the same clock
package tcc_pkg;
    localparam int VALUE_W = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_VALUE = 12'h000;
    localparam logic [11:0] OFF_OUTCTL = 12'h004;
    localparam logic [11:0] OFF_FSEL = 12'h008;
    localparam logic [11:0] OFF_EDGE = 12'h00C;
    localparam logic [1:0] IDX_VALUE = 2'h0;
    localparam logic [1:0] IDX_OUTCTL = 2'h1;
    localparam logic [1:0] IDX_FSEL = 2'h2;
    localparam logic [1:0] IDX_EDGE = 2'h3;
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic [7:0] OUTCTL_RST = 8'hF8;
    localparam logic [7:0] FSEL_RST = 8'hF2;
    localparam logic [15:0] EDGE_RST = 16'h0000;
    localparam logic [7:0] UPPER_ONES = 8'hF8;
    // function select: bits 7:4 read one, bit 3 reads zero
    localparam logic [7:0] FSEL_FIXED = 8'hF0;
    localparam int OUT_LVL_BIT = 0;
    localparam int NEXT_LVL_BIT = 1;
    localparam int CYC_FLAG_BIT = 2;
    localparam int IMPL_W = 3;
    localparam int FSEL_CAP_BIT = 0;
    localparam int FSEL_SIB_LSB = 1;
    localparam int EDGE_CH_LSB = 12;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam int EDGE_BOTH_BIT = 1;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tcc_apb_req_t;

    typedef struct packed {
        logic [15:0] count;
        logic run;
        logic tick;
    } tcc_timebase_t;

    typedef enum logic {TCC_BUS_IDLE, TCC_BUS_ACK} tcc_bus_state_t;
endpackage

// ---- hw/tcc_pin_sync.sv ----
// two-flop synchroniser for the channel pin with edge pulses
// assumes the pin is asynchronous to pclk
`timescale 1ns/1ps
module tcc_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic meta_nxt;
    logic sync_nxt;
    logic prev_nxt;

    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // reset to high so a high pin at release is not a rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else if (clk_en) begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign rise = sync_r && !prev_r;
    assign fall = !sync_r && prev_r;
endmodule

// ---- hw/tcc_match.sv ----
// comparator of the value register against the selected counter
// assumes counter, run and tick come from logic on pclk
`timescale 1ns/1ps
module tcc_match #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] count,
    input wire logic [WIDTH-1:0] value,
    input wire logic run,
    input wire logic tick,
    output logic match,
    output logic fire
);
    generate
        if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
            $error("tcc_match width out of range");
        end
    endgenerate

    // match stays high while the counter runs and sits on the value
    assign match = run && (count == value);
    // the tick ends the match, so this is the match falling edge
    assign fire = match && tick;
endmodule

// ---- verif/tcc_pin_model.sv ----
// far side of the channel pin: an external source, or a load
// assumes the bench sets src_en and src_level just after a pclk edge
`timescale 1ns/1ps
module tcc_pin_model (
    input wire logic pin_out,
    input wire logic oe_n,
    input wire logic src_en,
    input wire logic src_level,
    output logic pin
);
    // device wins while it drives; released line follows the source, or floats to pull-up when src_en is low
    assign pin = !oe_n ? pin_out : (src_en ? src_level : 1'b1);
endmodule

// ---- verif/tcc_top_tb_top.sv ----
// self-checking bench for the compare/capture channel
// assumes tcc_top with its apb slave and the pin model beside it
`timescale 1ns/1ps
module tcc_top_tb_top;
    logic pclk;
    logic presetn;
    logic clk_en;
    tcc_pkg::tcc_apb_req_t req;
    tcc_pkg::tcc_timebase_t tb_r;
    logic isp;
    logic pin;
    logic src_en;
    logic src_level;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_out;
    logic oe_n;
    logic rto_irq;
    logic cap_irq;
    logic [1:0] sib;
    logic [15:0] edge_sel;
    int bad_count = 0;
    int checks_done = 0;
    int rto_cnt = 0;
    int cap_cnt = 0;

    tcc_top i_tcc_top (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .apb_req(req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .timebase(tb_r),
        .instruction_start_phase(isp),
        .channel_pin_in(pin),
        .channel_pin_out(pin_out),
        .channel_pin_oe_n(oe_n),
        .rto_irq(rto_irq),
        .cap_irq(cap_irq),
        .sibling_mode(sib),
        .capture_edge_select(edge_sel)
    );

    tcc_pin_model i_tcc_pin_model (
        .pin_out(pin_out),
        .oe_n(oe_n),
        .src_en(src_en),
        .src_level(src_level),
        .pin(pin)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // irq outputs are one-cycle pulses, so count them at every edge
    always @(posedge pclk) begin
        if (rto_irq === 1'b1) rto_cnt++;
        if (cap_irq === 1'b1) cap_cnt++;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk(q, exp);
    endtask

    task automatic pulse(input logic [15:0] c, input logic r);
        @(posedge pclk);
        tb_r <= '{c, r, 1'b1};
        @(posedge pclk);
        tb_r.tick <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic cap_at(input logic l, input logic [15:0] c);
        @(posedge pclk);
        src_level <= l;
        tb_r.count <= c;
        repeat (6) @(posedge pclk);
    endtask

    task automatic t_reset;
        rd(12'h000, 32'h00000000);
        rd(12'h004, 32'h000000F8);
        rd(12'h008, 32'h000000F2);
        rd(12'h00C, 32'h00000000);
        chk({30'h0, sib}, 32'h00000001);
        chk({16'h0, edge_sel}, 32'h00000000);
        chk({31'h0, pin_out}, 32'h00000000);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        logic e;
        wr(12'h000, 32'hFFFF1234);
        rd(12'h000, 32'h00001234);
        wr(12'h004, 32'h000000FD);
        rd(12'h004, 32'h000000F9);
        wr(12'h008, 32'h00000004);
        rd(12'h008, 32'h000000F4);
        chk({30'h0, sib}, 32'h00000002);
        wr(12'h008, 32'h00000002);
        wr(12'h00C, 32'h0000A5C3);
        rd(12'h00C, 32'h0000A5C3);
        chk({16'h0, edge_sel}, 32'h0000A5C3);
        wr(12'h00C, 32'h00000000);
        apb(1'b1, 12'h010, 32'h00000001, q, e);
        chk({31'h0, e}, 32'h00000001);
        rd(12'h000, 32'h00001234);
        wr(12'h004, 32'h00000000);
    endtask

    task automatic t_compare;
        wr(12'h000, 32'h00000100);
        wr(12'h004, 32'h00000002);
        pulse(16'h0100, 1'b0);
        chk({31'h0, pin_out}, 32'h00000000);
        pulse(16'h00FF, 1'b1);
        chk({31'h0, pin_out}, 32'h00000000);
        chk({31'h0, oe_n}, 32'h00000000);
        pulse(16'h0100, 1'b1);
        chk({31'h0, pin_out}, 32'h00000001);
        chk(rto_cnt, 32'h00000000);
        rd(12'h004, 32'h000000FB);
        @(posedge pclk);
        isp <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(rto_cnt, 32'h00000001);
        wr(12'h004, 32'h00000002);
        repeat (4) @(posedge pclk);
        chk({31'h0, pin_out}, 32'h00000000);
        chk(rto_cnt, 32'h00000001);
        // a tick while the clock enable is low must be lost
        @(posedge pclk);
        clk_en <= 1'b0;
        pulse(16'h0100, 1'b1);
        clk_en <= 1'b1;
        chk({31'h0, pin_out}, 32'h00000000);
        chk(rto_cnt, 32'h00000001);
    endtask

    task automatic t_capture;
        int c0;
        wr(12'h00C, 32'h00001000);
        wr(12'h008, 32'h00000003);
        wr(12'h004, 32'h00000002);
        @(posedge pclk);
        tb_r <= '{16'h0200, 1'b1, 1'b0};
        repeat (4) @(posedge pclk);
        chk({31'h0, oe_n}, 32'h00000001);
        c0 = cap_cnt;
        cap_at(1'b1, 16'h0200);
        chk(cap_cnt, c0 + 1);
        rd(12'h000, 32'h00000200);
        rd(12'h004, 32'h000000FA);
        pulse(16'h0200, 1'b1);
        rd(12'h004, 32'h000000FA);
        chk(rto_cnt, 32'h00000001);
        cap_at(1'b0, 16'h0300);
        chk(cap_cnt, c0 + 1);
        cap_at(1'b1, 16'h0555);
        chk(cap_cnt, c0 + 2);
        rd(12'h000, 32'h00000555);
        rd(12'h004, 32'h000000FE);
        wr(12'h004, 32'h00000002);
        rd(12'h004, 32'h000000FA);
    endtask

    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        req = '0;
        tb_r = '0;
        isp = 1'b0;
        src_en = 1'b1;
        src_level = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_regs;
        t_compare;
        t_capture;
        summarize;
    end

    initial begin
        repeat (4000) @(posedge pclk);
        bad_count++;
        summarize;
    end
endmodule
